// File: logic/crt_timer.sv
// Local design decision: strobed register access.
`timescale 1ns/1ns
// Summary of operation
// - Overflow or down-count match sets overflow flag.
// - No overflow flag while baud source selected.
// - Trigger edge sets event flag outside down mode; down-mode overflow or match toggles it.
// - Event flag raises enabled timer interrupt.
// - Receive select picks baud source, forces baud.
// - Transmit select picks baud source, forces baud.
// - Trigger edges ignored unless enabled and non-baud.
// - Run bit gates counting; trigger reload or capture auto-clear still changes count when stopped.
// - Source select: prescaled clock or pin edges.
// - Baud mode counts every two core clocks.
// - Baud mode always reloads after overflow.
// - Reload mode reloads on overflow, or on trigger outside down mode.
// - Capture mode copies count on trigger edge.
// - Auto-clear zeroes count after capture.
// - Clock-out enable switches clock output function.
// - Down enable and trigger level set direction.
// - Capture registers double as reload value.
// - Hardware-clear bits for external interrupts two-five.

module crt_timer
  import crt_pkg::*;
(
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Register port
  input  wire crt_bus_req_t bus_req,
  output      logic [7:0]   rd_data,
  // Core side
  input  wire logic         timer_speed_select,
  input  wire logic         timer_irq_en,
  output      logic         timer_irq,
  output      logic         baud_tick,
  output      logic         rx_baud_sel,
  output      logic         tx_baud_sel,
  output      logic [3:0]   hw_clear,
  // Pins
  input  wire logic         trigger_pin,
  input  wire logic         count_input_pin_i,
  output      logic         count_input_pin_o,
  output      logic         count_input_pin_oe
);

  crt_state_t              st_q;
  crt_state_t              st_d;
  logic [CRT_NUM_PINS-1:0] pin_lvl;
  logic [CRT_NUM_PINS-1:0] pin_fall;
  logic [CRT_NUM_PINS-1:0] pin_raw;
  logic                    baud_mode;
  logic                    down_mode;
  logic                    count_dn;
  logic                    pre_tick;
  logic                    cnt_tick;
  logic                    ovf;
  logic                    unf;
  logic                    trig_ev;
  logic [3:0]              div;
  logic                    ctl_wr;
  logic                    mode_wr;
  logic                    cnt_wr;
  logic                    rcap_wr;

  assign pin_raw[CRT_PIN_TRIG] = trigger_pin;
  assign pin_raw[CRT_PIN_CNT]  = count_input_pin_i;

  crt_pin_sync u_sync (
    .clk   (clk),
    .rst   (rst),
    .pins  (pin_raw),
    .level (pin_lvl),
    .fall  (pin_fall)
  );

  assign ctl_wr  = bus_req.wr && (bus_req.addr == CRT_OFS_CTRL);
  assign mode_wr = bus_req.wr && (bus_req.addr == CRT_OFS_MODE);
  assign cnt_wr  = bus_req.wr && ((bus_req.addr == CRT_OFS_CNTL) ||
                                  (bus_req.addr == CRT_OFS_CNTH));
  assign rcap_wr = bus_req.wr && ((bus_req.addr == CRT_OFS_RCAPL) ||
                                  (bus_req.addr == CRT_OFS_RCAPH));

  assign baud_mode = st_q.ctrl.rclk || st_q.ctrl.tclk;

  assign div = baud_mode ? CRT_DIV_BAUD :
               (timer_speed_select ? CRT_DIV_FAST : CRT_DIV_SLOW);

  // The compare is at-or-above so a divisor change mid-count cannot stall.
  assign pre_tick = st_q.ctrl.run && (st_q.pre >= (div - CRT_PRE_ONE));

  assign cnt_tick = st_q.ctrl.run &&
                    ((baud_mode || !st_q.ctrl.cts) ? pre_tick : pin_fall[CRT_PIN_CNT]);

  assign down_mode = st_q.mode.down_count_enable && !st_q.ctrl.cprl && !baud_mode;

  assign count_dn = down_mode && !pin_lvl[CRT_PIN_TRIG];

  assign ovf = cnt_tick && !count_dn && (st_q.cnt == CRT_CNT_MAX);
  assign unf = cnt_tick && count_dn && (st_q.cnt == st_q.rcap);

  assign trig_ev = pin_fall[CRT_PIN_TRIG] && st_q.ctrl.exen && !baud_mode;

  always_comb begin
    st_d           = st_q;
    st_d.rdata     = CRT_BYTE_ZERO;
    st_d.baud_tick = 1'b0;
    st_d.pre       = (!st_q.ctrl.run || pre_tick) ? CRT_PRE_ZERO : st_q.pre + CRT_PRE_ONE;

    if (cnt_tick) begin
      if (ovf) begin
        st_d.cnt = (baud_mode || !st_q.ctrl.cprl) ? st_q.rcap : CRT_CNT_ZERO;
      end else if (unf) begin
        st_d.cnt = CRT_CNT_MAX;
      end else if (count_dn) begin
        st_d.cnt = st_q.cnt - CRT_CNT_ONE;
      end else begin
        st_d.cnt = st_q.cnt + CRT_CNT_ONE;
      end
    end

    // In up/down mode the trigger pin steers direction, so its edges do not reload.
    if (trig_ev && !down_mode) begin
      if (st_q.ctrl.cprl) begin
        st_d.rcap = st_q.cnt;
        if (st_q.mode.acl) begin
          st_d.cnt = CRT_CNT_ZERO;
        end
      end else begin
        st_d.cnt = st_q.rcap;
      end
    end

    if (ovf && st_q.mode.coe) begin
      st_d.clk_out = !st_q.clk_out;
    end
    st_d.baud_tick = ovf && baud_mode;

    if (ctl_wr) begin
      st_d.ctrl = crt_ctrl_t'(bus_req.wdata);
    end
    if (mode_wr) begin
      st_d.mode = crt_mode_t'(bus_req.wdata & CRT_MODE_WMASK);
    end

    // Hardware sets are applied after software writes, so a set beats a clear.
    // event flag toggle.
    if (down_mode && (ovf || unf)) begin
      st_d.ctrl.exf = !st_q.ctrl.exf;
    end
    if ((ovf || unf) && !baud_mode) begin
      st_d.ctrl.tf = 1'b1;
    end
    if (trig_ev && !down_mode) begin
      st_d.ctrl.exf = 1'b1;
    end

    if (bus_req.wr) begin
      case (bus_req.addr)
        CRT_OFS_RCAPL: begin
          st_d.rcap[7:0] = bus_req.wdata;
        end
        CRT_OFS_RCAPH: begin
          st_d.rcap[15:8] = bus_req.wdata;
        end
        CRT_OFS_CNTL: begin
          st_d.cnt[7:0] = bus_req.wdata;
        end
        CRT_OFS_CNTH: begin
          st_d.cnt[15:8] = bus_req.wdata;
        end
        default: begin
        end
      endcase
    end

    if (bus_req.rd) begin
      case (bus_req.addr)
        CRT_OFS_CTRL: begin
          st_d.rdata = st_q.ctrl;
        end
        CRT_OFS_MODE: begin
          st_d.rdata = st_q.mode & CRT_MODE_WMASK;
        end
        CRT_OFS_RCAPL: begin
          st_d.rdata = st_q.rcap[7:0];
        end
        CRT_OFS_RCAPH: begin
          st_d.rdata = st_q.rcap[15:8];
        end
        CRT_OFS_CNTL: begin
          st_d.rdata = st_q.cnt[7:0];
        end
        CRT_OFS_CNTH: begin
          st_d.rdata = st_q.cnt[15:8];
        end
        default: begin
          st_d.rdata = CRT_BYTE_ZERO;
        end
      endcase
    end

    st_d.irq = (st_q.ctrl.tf || st_q.ctrl.exf) && timer_irq_en;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= CRT_STATE_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign rd_data            = st_q.rdata;
  assign timer_irq          = st_q.irq;
  assign baud_tick          = st_q.baud_tick;
  assign rx_baud_sel        = st_q.ctrl.rclk;
  assign tx_baud_sel        = st_q.ctrl.tclk;
  assign hw_clear           = st_q.mode.hc;
  assign count_input_pin_o  = st_q.clk_out;
  assign count_input_pin_oe = st_q.mode.coe;

  property p_ovf_flag;
    @(posedge clk) disable iff (rst)
      (ovf && !baud_mode) |=> st_q.ctrl.tf;
  endproperty
  a_ovf_flag: assert property (p_ovf_flag)
    else $error("Overflow did not set the overflow flag.");

  property p_no_tf_baud;
    @(posedge clk) disable iff (rst)
      (baud_mode && !ctl_wr && !st_q.ctrl.tf) |=> !st_q.ctrl.tf;
  endproperty
  a_no_tf_baud: assert property (p_no_tf_baud)
    else $error("Overflow flag set while a baud source is selected.");

  property p_irq;
    @(posedge clk) disable iff (rst)
      (st_q.ctrl.exf && timer_irq_en) |=> timer_irq;
  endproperty
  a_irq: assert property (p_irq)
    else $error("Event flag did not raise the timer interrupt.");

  property p_no_trig;
    @(posedge clk) disable iff (rst)
      (!st_q.ctrl.exen && pin_fall[CRT_PIN_TRIG] && !ctl_wr && !st_q.ctrl.exf && !ovf && !unf)
        |=> !st_q.ctrl.exf;
  endproperty
  a_no_trig: assert property (p_no_trig)
    else $error("Disabled trigger pin set the event flag.");

  property p_run_hold;
    @(posedge clk) disable iff (rst)
      (!st_q.ctrl.run && !cnt_wr && !trig_ev) |=> $stable(st_q.cnt);
  endproperty
  a_run_hold: assert property (p_run_hold)
    else $error("Count changed while stopped.");

  property p_pin_count;
    @(posedge clk) disable iff (rst)
      (st_q.ctrl.run && st_q.ctrl.cts && !baud_mode) |-> (cnt_tick == pin_fall[CRT_PIN_CNT]);
  endproperty
  a_pin_count: assert property (p_pin_count)
    else $error("Counter mode did not follow count pin edges.");

  property p_baud_rate;
    @(posedge clk) disable iff (rst)
      (cnt_tick && baud_mode && st_q.ctrl.run) ##1 (baud_mode && st_q.ctrl.run && !cnt_tick)
        ##1 (baud_mode && st_q.ctrl.run) |-> cnt_tick;
  endproperty
  a_baud_rate: assert property (p_baud_rate)
    else $error("Baud mode did not count every two clocks.");

  property p_baud_reload;
    @(posedge clk) disable iff (rst)
      (ovf && baud_mode && !cnt_wr) |=> (st_q.cnt == $past(st_q.rcap));
  endproperty
  a_baud_reload: assert property (p_baud_reload)
    else $error("Baud mode overflow did not reload.");

  property p_trig_reload;
    @(posedge clk) disable iff (rst)
      (trig_ev && !down_mode && !st_q.ctrl.cprl && !cnt_wr) |=> (st_q.cnt == $past(st_q.rcap));
  endproperty
  a_trig_reload: assert property (p_trig_reload)
    else $error("Trigger edge did not reload the count.");

  property p_capture;
    @(posedge clk) disable iff (rst)
      (trig_ev && st_q.ctrl.cprl && !rcap_wr) |=> (st_q.rcap == $past(st_q.cnt));
  endproperty
  a_capture: assert property (p_capture)
    else $error("Trigger edge did not capture the count.");

  property p_auto_clear;
    @(posedge clk) disable iff (rst)
      (trig_ev && st_q.ctrl.cprl && st_q.mode.acl && !cnt_wr) |=> (st_q.cnt == CRT_CNT_ZERO);
  endproperty
  a_auto_clear: assert property (p_auto_clear)
    else $error("Capture auto clear did not zero the count.");

  property p_clk_out;
    @(posedge clk) disable iff (rst)
      (ovf && st_q.mode.coe) |=> (count_input_pin_o != $past(count_input_pin_o));
  endproperty
  a_clk_out: assert property (p_clk_out)
    else $error("Clock output did not toggle on overflow.");

  property p_down;
    @(posedge clk) disable iff (rst)
      (cnt_tick && count_dn && !unf && !cnt_wr) |=> (st_q.cnt == $past(st_q.cnt) - CRT_CNT_ONE);
  endproperty
  a_down: assert property (p_down)
    else $error("Low trigger level did not count down.");

endmodule // crt_timer

// File: common/crt_pkg.sv
package crt_pkg;

  // Register offsets on the register port.
  localparam logic [7:0] CRT_OFS_CTRL  = 8'hc8;
  localparam logic [7:0] CRT_OFS_MODE  = 8'hc9;
  localparam logic [7:0] CRT_OFS_RCAPL = 8'hca;
  localparam logic [7:0] CRT_OFS_RCAPH = 8'hcb;
  localparam logic [7:0] CRT_OFS_CNTL  = 8'hcc;
  localparam logic [7:0] CRT_OFS_CNTH  = 8'hcd;

  // Values after reset and fixed patterns.
  localparam logic [7:0]  CRT_CTRL_RST   = 8'h00;
  localparam logic [7:0]  CRT_MODE_RST   = 8'h00;
  localparam logic [15:0] CRT_WORD_RST   = 16'h0000;
  localparam logic [7:0]  CRT_BYTE_ZERO  = 8'h00;
  localparam logic [15:0] CRT_CNT_ZERO   = 16'h0000;
  localparam logic [15:0] CRT_CNT_MAX    = 16'hffff;
  localparam logic [15:0] CRT_CNT_ONE    = 16'h0001;
  localparam logic [7:0]  CRT_MODE_WMASK = 8'hfb;

  // Prescaler divisors in core clocks per count.
  localparam logic [3:0] CRT_DIV_BAUD = 4'h2;
  localparam logic [3:0] CRT_DIV_FAST = 4'h4;
  localparam logic [3:0] CRT_DIV_SLOW = 4'hc;
  localparam logic [3:0] CRT_PRE_ZERO = 4'h0;
  localparam logic [3:0] CRT_PRE_ONE  = 4'h1;

  // Pin positions in the synchroniser vector.
  localparam int CRT_NUM_PINS = 2;
  localparam int CRT_PIN_TRIG = 0;
  localparam int CRT_PIN_CNT  = 1;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } crt_bus_req_t;

  typedef struct packed {
    logic tf;
    logic exf;
    logic rclk;
    logic tclk;
    logic exen;
    logic run;
    logic cts;
    logic cprl;
  } crt_ctrl_t;

  typedef struct packed {
    logic [3:0] hc;
    logic       acl;
    logic       rsv;
    logic       coe;
    logic       down_count_enable;
  } crt_mode_t;

  typedef struct packed {
    crt_ctrl_t   ctrl;
    crt_mode_t   mode;
    logic [15:0] rcap;
    logic [15:0] cnt;
    logic [3:0]  pre;
    logic [7:0]  rdata;
    logic        irq;
    logic        baud_tick;
    logic        clk_out;
  } crt_state_t;

  typedef struct packed {
    logic [CRT_NUM_PINS-1:0] s1;
    logic [CRT_NUM_PINS-1:0] s2;
    logic [CRT_NUM_PINS-1:0] s3;
  } crt_sync_t;

  localparam crt_state_t CRT_STATE_RST = '{
    ctrl: CRT_CTRL_RST, mode: CRT_MODE_RST, rcap: CRT_WORD_RST, cnt: CRT_WORD_RST,
    pre: CRT_PRE_ZERO, rdata: CRT_BYTE_ZERO, irq: 1'b0, baud_tick: 1'b0, clk_out: 1'b0};

  localparam crt_sync_t CRT_SYNC_RST = '{s1: '1, s2: '1, s3: '1};

endpackage

// File: logic/crt_pin_sync.sv
`timescale 1ns/1ns

module crt_pin_sync
  import crt_pkg::*;
(
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst,
  // Raw pins
  input  wire logic [CRT_NUM_PINS-1:0] pins,
  // Synchronised results
  output      logic [CRT_NUM_PINS-1:0] level,
  output      logic [CRT_NUM_PINS-1:0] fall
);

  crt_sync_t st_q;
  crt_sync_t st_d;

  always_comb begin
    st_d    = st_q;
    st_d.s1 = pins;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= CRT_SYNC_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign level = st_q.s2;

  for (genvar i = 0; i < CRT_NUM_PINS; i++) begin : g_edge
    assign fall[i] = st_q.s3[i] & ~st_q.s2[i];
  end

endmodule // crt_pin_sync

// File: dv/crt_pin_model.sv
`timescale 1ns/1ns

module crt_pin_model (
  // Clock
  input  wire logic clk,
  // Timer side of the count pin
  input  wire logic pin_o,
  input  wire logic pin_oe,
  // Pin levels seen by the timer
  output      logic trig,
  output      logic cnt_pin
);
  logic cnt_drv;

  initial begin
    trig    = 1'b1;
    cnt_drv = 1'b1;
  end

  // The timer owns the count pin while its clock output is enabled.
  assign cnt_pin = pin_oe ? pin_o : cnt_drv;

  task automatic set_trig(input logic lvl);
    @(posedge clk);
    trig <= lvl;
  endtask

  // Each level is held long enough for the synchroniser to see it.
  task automatic pulse(input logic on_trig, input int n, input int hold);
    repeat (n) begin
      @(posedge clk);
      if (on_trig)
        trig <= 1'b0;
      else
        cnt_drv <= 1'b0;
      repeat (hold) @(posedge clk);
      trig    <= 1'b1;
      cnt_drv <= 1'b1;
      repeat (hold) @(posedge clk);
    end
  endtask
endmodule // crt_pin_model

// File: dv/capture_reload_timer_bench.sv
`timescale 1ns/1ns

module capture_reload_timer_bench
  import crt_pkg::*;
;
  logic         clk;
  logic         rst;
  crt_bus_req_t req;
  logic [7:0]   rd_data;
  logic         spd;
  logic         irq_en;
  logic         timer_irq;
  logic         baud_tick;
  logic         rx_sel;
  logic         tx_sel;
  logic [3:0]   hw_clear;
  logic         trig;
  logic         cnt_pin;
  logic         pin_o;
  logic         pin_oe;
  logic [31:0]  lfsr;
  logic [15:0]  v;
  logic [7:0]   d;
  int           num_errors;
  int           cmp_count;
  int           cyc;
  int           ticks;
  int           n0;
  int           mdl[$];

  crt_timer i_dut (
    .clk                (clk),
    .rst                (rst),
    .bus_req            (req),
    .rd_data            (rd_data),
    .timer_speed_select (spd),
    .timer_irq_en       (irq_en),
    .timer_irq          (timer_irq),
    .baud_tick          (baud_tick),
    .rx_baud_sel        (rx_sel),
    .tx_baud_sel        (tx_sel),
    .hw_clear           (hw_clear),
    .trigger_pin        (trig),
    .count_input_pin_i  (cnt_pin),
    .count_input_pin_o  (pin_o),
    .count_input_pin_oe (pin_oe)
  );

  crt_pin_model i_pins (
    .clk     (clk),
    .pin_o   (pin_o),
    .pin_oe  (pin_oe),
    .trig    (trig),
    .cnt_pin (cnt_pin)
  );

  initial begin
    clk = 1'b0;
  end

  always #10 clk = ~clk;

  always @(posedge clk) begin
    if (baud_tick === 1'b1)
      ticks <= ticks + 1;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      wrap_up();
    end
  end

  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] ad, input logic [7:0] dat);
    @(posedge clk);
    req.addr  <= ad;
    req.wdata <= dat;
    req.wr    <= 1'b1;
    @(posedge clk);
    req.wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] ad, output logic [7:0] dat);
    @(posedge clk);
    req.addr <= ad;
    req.rd   <= 1'b1;
    @(posedge clk);
    req.rd <= 1'b0;
    #1;
    dat = rd_data;
  endtask

  task automatic rchk(input logic [7:0] ad, input logic [7:0] exp);
    logic [7:0] got;
    rd(ad, got);
    chk(got, exp);
  endtask

  // Two reads of the low count byte exactly 120 clocks apart.
  task automatic delta(output logic [7:0] dv);
    logic [7:0] b0;
    logic [7:0] b1;
    rd(CRT_OFS_CNTL, b0);
    repeat (118) @(posedge clk);
    rd(CRT_OFS_CNTL, b1);
    dv = b1 - b0;
  endtask

  task automatic wrap_up();
    if (num_errors == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    rst        = 1'b1;
    req        = '0;
    spd        = 1'b0;
    irq_en     = 1'b1;
    lfsr       = 32'h88f1;
    num_errors = 0;
    cmp_count  = 0;
    cyc        = 0;
    ticks      = 0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (int i = 8'hc7; i <= 8'hce; i++)
      rchk(i[7:0], 8'h00);
    for (int i = 0; i < 4; i++) begin
      lfsr = nxt(lfsr);
      wr(8'hca + i[7:0], lfsr[7:0]);
      mdl.push_back(int'(lfsr[7:0]));
    end
    for (int i = 0; i < 4; i++)
      rchk(8'hca + i[7:0], 8'(mdl.pop_front()));
    lfsr = nxt(lfsr);
    d = lfsr[7:0] & 8'hfc;
    wr(CRT_OFS_MODE, d);
    rchk(CRT_OFS_MODE, d & 8'hfb);
    chk(hw_clear, d[7:4]);
    wr(CRT_OFS_MODE, 8'h00);
    wr(CRT_OFS_CTRL, 8'h04);
    for (int s = 0; s < 2; s++) begin
      @(posedge clk);
      spd <= s[0];
      delta(d);
      chk(d, s ? 8'h1e : 8'h0a);
    end
    wr(CRT_OFS_CTRL, 8'h00);
    delta(d);
    chk(d, 8'h00);
    wr(CRT_OFS_MODE, 8'h01);
    wr(CRT_OFS_RCAPL, 8'h00);
    wr(CRT_OFS_RCAPH, 8'h00);
    wr(CRT_OFS_CNTH, 8'h80);
    wr(CRT_OFS_CTRL, 8'h04);
    for (int t = 1; t >= 0; t--) begin
      i_pins.set_trig(t[0]);
      repeat (5) @(posedge clk);
      delta(d);
      chk(d, t ? 8'h1e : 8'he2);
    end
    // Counting down onto the reload value wraps the count to all ones and sets both flags.
    wr(CRT_OFS_CTRL, 8'h00);
    wr(CRT_OFS_CNTL, 8'h02);
    wr(CRT_OFS_CNTH, 8'h00);
    wr(CRT_OFS_CTRL, 8'h04);
    repeat (20) @(posedge clk);
    rchk(CRT_OFS_CNTH, 8'hff);
    rchk(CRT_OFS_CTRL, 8'hc4);
    i_pins.set_trig(1'b1);
    wr(CRT_OFS_CTRL, 8'h00);
    wr(CRT_OFS_MODE, 8'h02);
    wr(CRT_OFS_RCAPL, 8'h34);
    wr(CRT_OFS_RCAPH, 8'h12);
    wr(CRT_OFS_CNTL, 8'hfe);
    wr(CRT_OFS_CNTH, 8'hff);
    wr(CRT_OFS_CTRL, 8'h04);
    repeat (30) @(posedge clk);
    rchk(CRT_OFS_CNTH, 8'h12);
    rchk(CRT_OFS_CTRL, 8'h84);
    chk(timer_irq, 1'b1);
    chk({pin_oe, pin_o}, 2'b11);
    wr(CRT_OFS_CTRL, 8'h04);
    repeat (2) @(posedge clk);
    chk(timer_irq, 1'b0);
    wr(CRT_OFS_MODE, 8'h00);
    wr(CRT_OFS_RCAPL, 8'hf0);
    wr(CRT_OFS_RCAPH, 8'hff);
    // Start the count near the top so baud overflows begin within one period.
    wr(CRT_OFS_CNTL, 8'hf0);
    wr(CRT_OFS_CNTH, 8'hff);
    for (int b = 0; b < 2; b++) begin
      wr(CRT_OFS_CTRL, b ? 8'h1d : 8'h2d);
      i_pins.pulse(1'b1, 1, 4);
      repeat (40) @(posedge clk);
      n0 = ticks;
      repeat (320) @(posedge clk);
      chk(16'(ticks - n0), 16'h000a);
      chk({rx_sel, tx_sel}, b ? 2'b01 : 2'b10);
      rchk(CRT_OFS_CTRL, b ? 8'h1d : 8'h2d);
    end
    wr(CRT_OFS_CTRL, 8'h00);
    wr(CRT_OFS_MODE, 8'h08);
    lfsr = nxt(lfsr);
    v = lfsr[15:0];
    wr(CRT_OFS_CNTL, v[7:0]);
    wr(CRT_OFS_CNTH, v[15:8]);
    wr(CRT_OFS_CTRL, 8'h09);
    i_pins.pulse(1'b1, 1, 3);
    repeat (6) @(posedge clk);
    rchk(CRT_OFS_RCAPL, v[7:0]);
    rchk(CRT_OFS_RCAPH, v[15:8]);
    rchk(CRT_OFS_CNTH, 8'h00);
    rchk(CRT_OFS_CTRL, 8'h49);
    chk(timer_irq, 1'b1);
    wr(CRT_OFS_CTRL, 8'h01);
    i_pins.pulse(1'b1, 1, 3);
    repeat (6) @(posedge clk);
    rchk(CRT_OFS_CTRL, 8'h01);
    rchk(CRT_OFS_RCAPL, v[7:0]);
    wr(CRT_OFS_CTRL, 8'h40);
    repeat (2) @(posedge clk);
    chk(timer_irq, 1'b1);
    wr(CRT_OFS_CTRL, 8'h06);
    i_pins.pulse(1'b0, 5, 3);
    repeat (6) @(posedge clk);
    rchk(CRT_OFS_CNTL, 8'h05);
    wr(CRT_OFS_CTRL, 8'h08);
    i_pins.pulse(1'b1, 1, 3);
    repeat (6) @(posedge clk);
    rchk(CRT_OFS_CNTL, v[7:0]);
    wrap_up();
  end
endmodule // capture_reload_timer_bench
